// ===== hdl/cpt_consts.vh
/*
 * Constants of the codec programmed-I/O transfer block: register indices,
 * field positions, reset values, format codes, FIFO size and sample timing.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef CPT_CONSTS_VH
`define CPT_CONSTS_VH

// register indices; byte address is four times the index
`define CPT_IDX_FLAGS     4'h4
`define CPT_IDX_STATUS    4'h5
`define CPT_IDX_DATA      4'h6
`define CPT_IDX_RSVD      4'h7
`define CPT_IDX_PCFG      4'h8
`define CPT_IDX_CCFG      4'hA

// transfer_status fields
`define CPT_ST_CUL        0
`define CPT_ST_CLR        1
`define CPT_ST_CDR        2
`define CPT_ST_CFH        3
`define CPT_ST_PUL        4
`define CPT_ST_PLR        5
`define CPT_ST_PDR        6
`define CPT_ST_PFH        7

// playback_config fields (capture config shares the layout of bits 0,2..5)
`define CPT_CFG_ON        0
`define CPT_CFG_SEL       1
`define CPT_CFG_STEREO    2
`define CPT_CFG_COMPAND   3
`define CPT_CFG_FMT_LO    4
`define CPT_CFG_FMT_HI    5
`define CPT_CFG_ZERO      6
`define CPT_CFG_SUPP      7

// flag register fields
`define CPT_FL_COR        4
`define CPT_FL_PUR        5

`define CPT_PCFG_RESET    8'h00
`define CPT_CCFG_RESET    8'h00
`define CPT_DATA_RESET    8'h00

// {fmt1, fmt0, compand} codes
`define CPT_FMT_U8        3'b000
`define CPT_FMT_ULAW      3'b001
`define CPT_FMT_LE16      3'b010
`define CPT_FMT_ALAW      3'b011
`define CPT_FMT_BE16      3'b110

// sample width classes
`define CPT_CLS_8         2'b00
`define CPT_CLS_LE        2'b01
`define CPT_CLS_BE        2'b10

// fifo of 4-byte groups: 2**4 groups = 64 bytes
`define CPT_FIFO_AW       4

// timing
`define CPT_CLK_HZ        200000000
`define CPT_SAMPLE_HZ     48000
`define CPT_SAMPLE_CYCLES (`CPT_CLK_HZ / `CPT_SAMPLE_HZ)

`endif

// ===== hdl/cpt_pio.v
/*
 * Codec programmed-I/O transfer block: status, shared data port, playback
 * and capture configuration, 4-byte group packing and two group FIFOs.
 * Assumes an Avalon-MM master using word addresses, a converter that gives
 * one capture sample per adc_valid pulse, and a single 200 MHz clock.
 */
// The implementer's own choice: register access over Avalon-MM.
`include "cpt_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module cpt_pio #(
	parameter FIFO_AW       = `CPT_FIFO_AW,
	parameter SAMPLE_CYCLES = `CPT_SAMPLE_CYCLES
) (
	input  wire        clock,
	input  wire        nrst,
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire [15:0] adc_left,
	input  wire [15:0] adc_right,
	input  wire        adc_valid,
	input  wire        codec_irq,
	output wire [15:0] dac_left,
	output wire [15:0] dac_right,
	output wire        dac_valid,
	output wire        play_dma_req
);

	localparam [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};
	localparam [FIFO_AW:0] HALF  = {2'b01, {(FIFO_AW-1){1'b0}}};
	localparam [31:0]      TICK_FULL = SAMPLE_CYCLES - 1;
	// divider compare is 16 bits wide; cut the parameter on purpose
	localparam [15:0]      TICK_LAST = TICK_FULL[15:0];

	// width class of a format code; reserved codes fall back to 8-bit
	// format decode
	function [1:0] fmt_class;
		input [2:0] code;
		begin
			case (code)
			`CPT_FMT_LE16: fmt_class = `CPT_CLS_LE;
			`CPT_FMT_BE16: fmt_class = `CPT_CLS_BE;
			default:       fmt_class = `CPT_CLS_8;
			endcase
		end
	endfunction

	// {left/right, upper/lower} of the byte at position ptr in a group
	function [1:0] byte_flags;
		input [1:0] cls;
		input       stereo;
		input [1:0] ptr;
		reg         ul;
		reg         lr;
		begin
			ul = 1'b1;
			lr = 1'b1;
			if (cls == `CPT_CLS_LE)
				ul = ptr[0];
			else if (cls == `CPT_CLS_BE)
				ul = ~ptr[0];
			if (stereo && cls == `CPT_CLS_8)
				lr = ~ptr[0];
			else if (stereo)
				lr = ~ptr[1];
			byte_flags = {lr, ul};
		end
	endfunction

	// 8-bit byte to 16-bit output; companded bytes pass raw to the converter
	function [15:0] widen8;
		input [7:0] b;
		input       compand;
		begin
			if (compand)
				widen8 = {b, 8'h00};
			else
				widen8 = {~b[7], b[6:0], 8'h00};
		end
	endfunction

	// registers
	reg [7:0]  pcfg_reg;
	reg [7:0]  ccfg_reg;
	reg        ack_reg;
	reg [31:0] readdata_reg;
	reg        pur_reg;
	reg        cor_reg;

	// playback path state
	reg [31:0]        p_mem [0:DEPTH-1];
	reg [FIFO_AW-1:0] p_wr_reg;
	reg [FIFO_AW-1:0] p_rd_reg;
	reg [FIFO_AW:0]   p_count_reg;
	reg [31:0]        p_asm_reg;
	reg [2:0]         pw_ptr_reg;
	reg [1:0]         p_sub_reg;
	reg [15:0]        tick_cnt_reg;
	reg [15:0]        dac_left_reg;
	reg [15:0]        dac_right_reg;
	reg               dac_valid_reg;

	// capture path state
	reg [31:0]        c_mem [0:DEPTH-1];
	reg [FIFO_AW-1:0] c_wr_reg;
	reg [FIFO_AW-1:0] c_rd_reg;
	reg [FIFO_AW:0]   c_count_reg;
	reg [31:0]        c_asm_reg;
	reg [2:0]         c_cnt_reg;
	reg [1:0]         c_ptr_reg;
	reg               c_stale_reg;
	reg [7:0]         c_last_reg;

	// bus handshake: one wait cycle, side effects on the first edge only
	wire acc   = (avs_read | avs_write) & ~ack_reg;
	wire do_rd = avs_read & acc;
	wire do_wr = avs_write & acc & avs_byteenable[0];
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign avs_readdata    = readdata_reg;

	// decoded configuration
	wire       p_on      = pcfg_reg[`CPT_CFG_ON];
	wire       p_stereo  = pcfg_reg[`CPT_CFG_STEREO];
	wire       p_compand = pcfg_reg[`CPT_CFG_COMPAND];
	wire [1:0] p_cls     = fmt_class(pcfg_reg[`CPT_CFG_FMT_HI:`CPT_CFG_COMPAND]);
	wire       c_on      = ccfg_reg[`CPT_CFG_ON];
	wire       c_stereo  = ccfg_reg[`CPT_CFG_STEREO];
	wire       c_compand = ccfg_reg[`CPT_CFG_COMPAND];
	wire [1:0] c_cls     = fmt_class(ccfg_reg[`CPT_CFG_FMT_HI:`CPT_CFG_COMPAND]);

	// sample-rate enable pulse from a divider
	wire tick = (tick_cnt_reg == TICK_LAST);
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			tick_cnt_reg <= 16'h0000;
		else if (tick)
			tick_cnt_reg <= 16'h0000;
		else
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
	end

	// playback fifo status
	wire p_empty = (p_count_reg == {(FIFO_AW+1){1'b0}});
	wire p_full  = (p_count_reg == DEPTH);
	wire [FIFO_AW:0] p_room = DEPTH - p_count_reg;

	wire p_push = pw_ptr_reg[2] & ~p_full;

	// unpack the head group at the current sub position
	// playback byte order
	wire [31:0] p_head = p_mem[p_rd_reg];
	wire [7:0]  pb0 = p_head[{p_sub_reg, 3'b000} +: 8];
	wire [7:0]  pb1 = p_head[{p_sub_reg + 2'b01, 3'b000} +: 8];
	reg  [15:0] un_left;
	reg  [15:0] un_right;
	reg  [2:0]  un_step;
	always @* begin
		un_left  = widen8(pb0, p_compand);
		un_right = un_left;
		un_step  = 3'd1;
		if (p_cls == `CPT_CLS_8) begin
			if (p_stereo) begin
				un_right = widen8(pb1, p_compand);
				un_step  = 3'd2;
			end
		end else begin
			un_left  = (p_cls == `CPT_CLS_LE) ? {pb1, pb0} : {pb0, pb1};
			un_right = un_left;
			un_step  = 3'd2;
			if (p_stereo) begin
				un_left  = (p_cls == `CPT_CLS_LE) ? p_head[15:0]
				           : {p_head[7:0], p_head[15:8]};
				un_right = (p_cls == `CPT_CLS_LE) ? p_head[31:16]
				           : {p_head[23:16], p_head[31:24]};
				un_step  = 3'd4;
			end
		end
	end

	wire [2:0] p_sub_sum = {1'b0, p_sub_reg} + un_step;
	wire p_take = tick & p_on & ~p_empty;
	wire p_pop  = p_take & p_sub_sum[2];

	// playback fifo storage, no reset on the array
	always @(posedge clock) begin
		if (p_push)
			p_mem[p_wr_reg] <= p_asm_reg;
	end

	// playback pointers, host byte pointer and assembly
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			p_wr_reg    <= {FIFO_AW{1'b0}};
			p_rd_reg    <= {FIFO_AW{1'b0}};
			p_count_reg <= {(FIFO_AW+1){1'b0}};
			p_asm_reg   <= 32'h00000000;
			pw_ptr_reg  <= 3'd0;
			p_sub_reg   <= 2'd0;
		end else begin
			if (p_push)
				p_wr_reg <= p_wr_reg + 1'b1;
			if (p_pop)
				p_rd_reg <= p_rd_reg + 1'b1;
			if (p_push && !p_pop)
				p_count_reg <= p_count_reg + 1'b1;
			else if (p_pop && !p_push)
				p_count_reg <= p_count_reg - 1'b1;
			if (p_take)
				p_sub_reg <= p_sub_reg + un_step[1:0];
			if (p_push)
				pw_ptr_reg <= 3'd0;
			else if (do_wr && avs_address == `CPT_IDX_DATA && !pw_ptr_reg[2]) begin
				p_asm_reg[{pw_ptr_reg[1:0], 3'b000} +: 8] <= avs_writedata[7:0];
				pw_ptr_reg <= pw_ptr_reg + 3'd1;
			end
		end
	end

	// converter output; starved ticks hold or zero the output
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dac_left_reg  <= 16'h0000;
			dac_right_reg <= 16'h0000;
			dac_valid_reg <= 1'b0;
		end else begin
			dac_valid_reg <= tick & p_on;
			if (tick && p_on && pcfg_reg[`CPT_CFG_ZERO]) begin
				dac_left_reg  <= 16'h0000;
				dac_right_reg <= 16'h0000;
			end else if (p_take) begin
				dac_left_reg  <= un_left;
				dac_right_reg <= un_right;
			end
		end
	end
	assign dac_left  = dac_left_reg;
	assign dac_right = dac_right_reg;
	assign dac_valid = dac_valid_reg;

	// DMA only when select is 0
	assign play_dma_req = p_on & ~pcfg_reg[`CPT_CFG_SEL] & ~pw_ptr_reg[2] & ~p_full
	                      & ~(pcfg_reg[`CPT_CFG_SUPP] & codec_irq);

	// capture packing of one converter sample into bytes
	// capture byte order
	reg [31:0] cw;
	reg [2:0]  cn;
	always @* begin
		cw = 32'h00000000;
		cn = 3'd1;
		if (c_cls == `CPT_CLS_8) begin
			cw[7:0] = c_compand ? adc_left[15:8] : {~adc_left[15], adc_left[14:8]};
			if (c_stereo) begin
				cw[15:8] = c_compand ? adc_right[15:8]
				           : {~adc_right[15], adc_right[14:8]};
				cn = 3'd2;
			end
		end else begin
			cw[15:0] = (c_cls == `CPT_CLS_LE) ? adc_left
			           : {adc_left[7:0], adc_left[15:8]};
			cn = 3'd2;
			if (c_stereo) begin
				cw[31:16] = (c_cls == `CPT_CLS_LE) ? adc_right
				            : {adc_right[7:0], adc_right[15:8]};
				cn = 3'd4;
			end
		end
	end

	wire [31:0] c_shifted = cw << {c_cnt_reg[1:0], 3'b000};
	wire [2:0]  c_sum     = c_cnt_reg + cn;
	wire        c_in      = adc_valid & c_on;
	wire        c_done    = c_in & c_sum[2];
	wire        c_full    = (c_count_reg == DEPTH);
	wire        c_empty   = (c_count_reg == {(FIFO_AW+1){1'b0}});
	wire        c_push    = c_done & ~c_full & ~cor_reg;
	wire        c_rd_data = do_rd & (avs_address == `CPT_IDX_DATA);
	wire        c_pop     = c_rd_data & ~c_stale_reg & (c_ptr_reg == 2'd3);
	wire [31:0] c_head    = c_mem[c_rd_reg];
	wire [7:0]  c_byte    = c_stale_reg ? c_last_reg : c_head[{c_ptr_reg, 3'b000} +: 8];

	// capture fifo storage
	always @(posedge clock) begin
		if (c_push)
			c_mem[c_wr_reg] <= c_asm_reg | c_shifted;
	end

	// capture assembly, fifo pointers and host byte pointer
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			c_wr_reg    <= {FIFO_AW{1'b0}};
			c_rd_reg    <= {FIFO_AW{1'b0}};
			c_count_reg <= {(FIFO_AW+1){1'b0}};
			c_asm_reg   <= 32'h00000000;
			c_cnt_reg   <= 3'd0;
			c_ptr_reg   <= 2'd0;
			c_stale_reg <= 1'b1;
			c_last_reg  <= `CPT_DATA_RESET;
		end else begin
			if (c_done) begin
				c_asm_reg <= 32'h00000000;
				c_cnt_reg <= 3'd0;
			end else if (c_in) begin
				c_asm_reg <= c_asm_reg | c_shifted;
				c_cnt_reg <= c_sum;
			end
			if (c_push)
				c_wr_reg <= c_wr_reg + 1'b1;
			if (c_pop)
				c_rd_reg <= c_rd_reg + 1'b1;
			if (c_push && !c_pop)
				c_count_reg <= c_count_reg + 1'b1;
			else if (c_pop && !c_push)
				c_count_reg <= c_count_reg - 1'b1;
			if (c_rd_data && !c_stale_reg)
				c_last_reg <= c_byte;
			// advance and park on last byte
			if (c_pop) begin
				if (c_count_reg == {{FIFO_AW{1'b0}}, 1'b1} && !c_push)
					c_stale_reg <= 1'b1;
				else
					c_ptr_reg <= 2'd0;
			end else if (c_rd_data && !c_stale_reg) begin
				c_ptr_reg <= c_ptr_reg + 2'd1;
			end else if (c_stale_reg && !c_empty) begin
				c_stale_reg <= 1'b0;
				c_ptr_reg   <= 2'd0;
			end
		end
	end

	// sticky flags; the set wins over a clear in the same cycle
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pur_reg <= 1'b0;
			cor_reg <= 1'b0;
		end else begin
			if (tick && p_on && p_empty)
				pur_reg <= 1'b1;
			else if (p_push)
				pur_reg <= 1'b0;
			if (c_done && c_full)
				cor_reg <= 1'b1;
			else if (c_pop)
				cor_reg <= 1'b0;
		end
	end

	// status byte
	wire [1:0] c_flags = byte_flags(c_cls, c_stereo, c_ptr_reg);
	wire [1:0] p_ptr2  = pw_ptr_reg[2] ? 2'd3 : pw_ptr_reg[1:0];
	wire [1:0] p_flags = byte_flags(p_cls, p_stereo, p_ptr2);
	wire [7:0] status;
	assign status[`CPT_ST_CUL] = c_flags[0];
	assign status[`CPT_ST_CLR] = c_flags[1];
	assign status[`CPT_ST_CDR] = ~c_stale_reg & ~c_empty;
	assign status[`CPT_ST_CFH] = (c_count_reg >= HALF);
	assign status[`CPT_ST_PUL] = p_flags[0];
	assign status[`CPT_ST_PLR] = p_flags[1];
	assign status[`CPT_ST_PDR] = ~pw_ptr_reg[2] & ~p_full;
	assign status[`CPT_ST_PFH] = (p_room >= HALF);

	// read mux; unmapped and reserved words read zero
	reg [7:0] rd_byte;
	always @* begin
		case (avs_address)
		`CPT_IDX_FLAGS:  rd_byte = {2'b00, pur_reg, cor_reg, 4'h0};
		`CPT_IDX_STATUS: rd_byte = status;
		`CPT_IDX_DATA:   rd_byte = c_byte;
		`CPT_IDX_PCFG:   rd_byte = pcfg_reg;
		`CPT_IDX_CCFG:   rd_byte = ccfg_reg;
		default:         rd_byte = 8'h00;
		endcase
	end

	// bus slave: acknowledge, read data and configuration writes
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ack_reg      <= 1'b0;
			readdata_reg <= 32'h00000000;
			pcfg_reg     <= `CPT_PCFG_RESET;
			ccfg_reg     <= `CPT_CCFG_RESET;
		end else begin
			ack_reg <= acc;
			if (do_rd)
				readdata_reg <= {24'h000000, rd_byte};
			if (do_wr && avs_address == `CPT_IDX_PCFG)
				pcfg_reg <= avs_writedata[7:0];
			if (do_wr && avs_address == `CPT_IDX_CCFG)
				ccfg_reg <= {2'b00, avs_writedata[5:2], 1'b0, avs_writedata[0]};
		end
	end

endmodule

`default_nettype wire

// ===== bench/cpt_pio_chk.sv
/* checker for cpt_pio: bus answer, status bits, dac output, dma request.
   assumes it is bound to cpt_pio and that all runs on one clock */
`timescale 1ns/1ps
`default_nettype none
module cpt_pio_chk #(
	parameter FIFO_AW       = 4,
	parameter SAMPLE_CYCLES = 16
) (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        codec_irq,
	input wire logic [15:0] dac_left,
	input wire logic [15:0] dac_right,
	input wire logic        dac_valid,
	input wire logic        play_dma_req
);
	logic [7:0] pcfg_reg;
	logic [7:0] ccfg_reg;
	wire        rd_done = avs_read && !avs_waitrequest;
	wire        st_rd   = rd_done && avs_address == 4'h5;
	wire        p16     = pcfg_reg[5:3] == 3'b010 || pcfg_reg[5:3] == 3'b110;
	wire        c16     = ccfg_reg[5:3] == 3'b010 || ccfg_reg[5:3] == 3'b110;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// shadow configs, updated on the edge the write is taken
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pcfg_reg <= 8'h00;
			ccfg_reg <= 8'h00;
		end else if (avs_write && avs_waitrequest && avs_byteenable[0]) begin
			if (avs_address == 4'h8)
				pcfg_reg <= avs_writedata[7:0];
			if (avs_address == 4'hA)
				ccfg_reg <= avs_writedata[7:0];
		end
	end
	AST_ONE_WAIT: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one wait cycle");
	AST_RSVD_ZERO: assert property (
		rd_done && avs_address == 4'h7 |-> avs_readdata == 32'h00000000)
		else $error("reserved location read not zero");
	AST_CAP_8BIT: assert property (st_rd && !c16 |-> avs_readdata[0])
		else $error("capture upper flag low in 8-bit mode");
	AST_PLAY_8BIT: assert property (st_rd && !p16 |-> avs_readdata[4])
		else $error("playback upper flag low in 8-bit mode");
	AST_MONO_LR: assert property (
		st_rd && !ccfg_reg[2] && !pcfg_reg[2] |-> avs_readdata[1] && avs_readdata[5])
		else $error("channel flag low in mono");
	AST_HALF_FRESH: assert property (st_rd && avs_readdata[3] |-> avs_readdata[2])
		else $error("capture half full without fresh data");
	AST_DMA_GATE: assert property (
		play_dma_req |-> pcfg_reg[0] && !pcfg_reg[1] && !(pcfg_reg[7] && codec_irq))
		else $error("dma request while not permitted");
	AST_DAC_ON: assert property ($rose(dac_valid) |-> $past(pcfg_reg[0]) ##1 !dac_valid)
		else $error("dac pulse while playback off or too long");
	AST_ZERO_OUT: assert property (
		dac_valid && $past(pcfg_reg[6]) |-> dac_left == 16'h0000 && dac_right == 16'h0000)
		else $error("dac not zero while forced");
	COV_DAC: cover property (dac_valid);
	COV_DMA: cover property (play_dma_req);
	COV_DATA: cover property (rd_done && avs_address == 4'h6);
endmodule
bind cpt_pio cpt_pio_chk #(.FIFO_AW(FIFO_AW), .SAMPLE_CYCLES(SAMPLE_CYCLES)) i_chk (
	.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .codec_irq(codec_irq),
	.dac_left(dac_left), .dac_right(dac_right), .dac_valid(dac_valid),
	.play_dma_req(play_dma_req));
`default_nettype wire

// ===== bench/cpt_host.sv
/* host model: avalon master used by the bench for register and data access.
   assumes each task call starts just after a rising clock edge */
`timescale 1ns/1ps
`default_nettype none
module cpt_host (
	input  wire logic        clock,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output var  logic [3:0]  avs_address,
	output var  logic        avs_read,
	output var  logic        avs_write,
	output var  logic [31:0] avs_writedata,
	output var  logic [3:0]  avs_byteenable
);
	// idle bus at time zero
	initial begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h1;
	end
	// one access; an edge passes first so a strobe never toggles twice in a step
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clock); while (avs_waitrequest);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// released lines carry a changed pattern, not the last value
		avs_address <= ~a;
		avs_writedata <= ~{24'h000000, d};
	endtask
	task automatic wr_group(input logic [31:0] g);
		logic [7:0] q;
		for (int b = 0; b < 4; b++)
			acc(1'b1, 4'h6, g[8*b +: 8], q);
	endtask
endmodule
`default_nettype wire

// ===== bench/tb_codec_pio_transfer_format.sv
/* self-checking bench for cpt_pio with the host model on its bus.
   assumes a short sample period so playback ticks come often */
`timescale 1ns/1ps
`default_nettype none
module tb_codec_pio_transfer_format;
	localparam SC = 16;
	logic        clock;
	logic        nrst;
	logic        adc_valid;
	logic        codec_irq;
	logic [15:0] adc_left;
	logic [15:0] adc_right;
	wire  [3:0]  avs_address;
	wire  [3:0]  avs_byteenable;
	wire  [31:0] avs_writedata;
	wire  [31:0] avs_readdata;
	wire         avs_read;
	wire         avs_write;
	wire         avs_waitrequest;
	wire  [15:0] dac_left;
	wire  [15:0] dac_right;
	wire         dac_valid;
	wire         play_dma_req;
	int          n_fail;
	int          cmp_count;
	int          cyc = 0;
	logic [7:0]  q;
	logic [31:0] g;

	cpt_pio #(.FIFO_AW(4), .SAMPLE_CYCLES(SC)) i_dut (.clock(clock), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.adc_left(adc_left), .adc_right(adc_right), .adc_valid(adc_valid),
		.codec_irq(codec_irq), .dac_left(dac_left), .dac_right(dac_right),
		.dac_valid(dac_valid), .play_dma_req(play_dma_req));
	cpt_host i_host (.clock(clock), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable));

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// hang guard, far above the thousand or so cycles the run needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			close_out;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdm(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		i_host.acc(1'b0, a, 8'h00, q);
		chk({24'h000000, q & m}, {24'h000000, e});
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_host.acc(1'b1, a, d, q);
	endtask
	task automatic pulse(input logic [15:0] l, input logic [15:0] r);
		@(posedge clock);
		adc_left <= l;
		adc_right <= r;
		adc_valid <= 1'b1;
		@(posedge clock);
		adc_valid <= 1'b0;
	endtask
	// bounded wait for the next dac pulse
	task automatic wait_dac;
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (dac_valid !== 1'b1 && n < 4 * SC);
		chk({31'h0, dac_valid}, 32'h1);
	endtask
	function automatic logic [31:0] grp(input int i);
		logic [7:0] k;
		k = i[7:0];
		return {8'h40 + k, 8'h30 + k, 8'h20 + k, 8'h10 + k};
	endfunction
	task automatic t_reset;
		rdm(4'h5, 8'hFF, 8'hF3);
		rdm(4'h7, 8'hFF, 8'h00);
		wr(4'h8, 8'hA4);
		rdm(4'h8, 8'hFF, 8'hA4);
		wr(4'h8, 8'h00);
		wr(4'h5, 8'h00);
		wr(4'hF, 8'hFF);
		rdm(4'h5, 8'hFF, 8'hF3);
		rdm(4'hF, 8'hFF, 8'h00);
	endtask
	task automatic t_formats;
		for (int c = 0; c < 8; c++) begin
			wr(4'h8, {2'b00, c[2:0], 3'b000});
			rdm(4'h5, 8'h30, (c == 2) ? 8'h20 : 8'h30);
		end
		wr(4'h8, 8'h00);
	endtask
	task automatic t_capture;
		wr(4'hA, 8'h15);
		pulse(16'h1234, 16'hABCD);
		for (int b = 0; b < 4; b++) begin
			rdm(4'h5, 8'h07, {5'h00, 1'b1, b < 2, b[0]});
			rdm(4'h6, 8'hFF, g_cap(b));
		end
		rdm(4'h5, 8'h04, 8'h00);
		rdm(4'h6, 8'hFF, 8'hAB);
	endtask
	function automatic logic [7:0] g_cap(input int b);
		logic [31:0] v;
		v = 32'hABCD1234;
		return v[8*b +: 8];
	endfunction
	task automatic t_overrun;
		for (int i = 0; i < 17; i++) begin
			pulse(i[15:0], ~i[15:0]);
			if (i == 6) rdm(4'h5, 8'h08, 8'h00);
			if (i == 7) rdm(4'h5, 8'h08, 8'h08);
		end
		rdm(4'h4, 8'h10, 8'h10);
		for (int b = 0; b < 4; b++)
			rdm(4'h6, 8'hFF, (b < 2) ? 8'h00 : 8'hFF);
		rdm(4'h4, 8'h10, 8'h00);
		wr(4'hA, 8'h00);
	endtask
	task automatic t_playback;
		wr(4'h8, 8'h16);
		g = grp(0);
		for (int b = 0; b < 4; b++) begin
			rdm(4'h5, 8'h30, {2'b00, b < 2, b[0], 4'h0});
			wr(4'h6, g[8*b +: 8]);
		end
		for (int i = 1; i < 17; i++) begin
			i_host.wr_group(grp(i));
			if (i == 7) rdm(4'h5, 8'h80, 8'h80);
			if (i == 8) rdm(4'h5, 8'h80, 8'h00);
		end
		rdm(4'h5, 8'hC0, 8'h00);
		wr(4'h6, 8'hEE);
		wr(4'h8, 8'h17);
		for (int i = 0; i < 17; i++) begin
			wait_dac;
			g = grp(i);
			chk({16'h0000, dac_left}, {16'h0000, g[15:0]});
			chk({16'h0000, dac_right}, {16'h0000, g[31:16]});
		end
		wait_dac;
		rdm(4'h4, 8'h20, 8'h20);
		wr(4'h8, 8'h57);
		wait_dac;
		wait_dac;
		chk({16'h0000, dac_left}, 32'h0);
		wr(4'h8, 8'h16);
		i_host.wr_group(grp(0));
		rdm(4'h4, 8'h20, 8'h00);
	endtask
	task automatic t_dma;
		wr(4'h8, 8'h01);
		chk({31'h0, play_dma_req}, 32'h1);
		@(posedge clock) codec_irq <= 1'b1;
		@(posedge clock);
		chk({31'h0, play_dma_req}, 32'h1);
		wr(4'h8, 8'h81);
		chk({31'h0, play_dma_req}, 32'h0);
		@(posedge clock) codec_irq <= 1'b0;
		@(posedge clock);
		chk({31'h0, play_dma_req}, 32'h1);
		wr(4'h8, 8'h03);
		chk({31'h0, play_dma_req}, 32'h0);
		wr(4'h8, 8'h00);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// reset for six cycles, then the scenarios in turn
	initial begin
		nrst = 1'b0;
		adc_valid = 1'b0;
		adc_left = 16'h0000;
		adc_right = 16'h0000;
		codec_irq = 1'b0;
		n_fail = 0;
		cmp_count = 0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		t_reset;
		t_formats;
		t_capture;
		t_overrun;
		t_playback;
		t_dma;
		close_out;
	end
endmodule
`default_nettype wire
